// File: crw_pkg.sv
// charger control register bank: offsets, resets, fields and timing
// assumes a 10 MHz mclk and AXI4-Lite word addressing (byte = index * 4)
package crw_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SEC_NS = 1_000_000_000;
  localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
  localparam int OV_DEG_NS = 1000;
  localparam int OV_DEG_CYCLES =
    (OV_DEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLUGOUT_BASE_NS = 16_000_000;
  localparam int PLUGOUT_BASE_CYCLES = PLUGOUT_BASE_NS / CLK_PERIOD_NS;
  localparam logic [11:0] WDT_LONG_SECONDS = 12'hbb8;
  localparam logic [3:0] WDT_LOCKOUT_CODE = 4'h8;

  // register slots
  localparam int NREG = 14;
  localparam int S_MAIN = 0;
  localparam int S_HV = 1;
  localparam int S_CMP = 2;
  localparam int S_CV = 3;
  localparam int S_CS = 4;
  localparam int S_OV = 5;
  localparam int S_BP = 6;
  localparam int S_WDT = 7;
  localparam int S_FLAG = 8;
  localparam int S_DL = 9;
  localparam int S_BG = 10;
  localparam int S_DETA = 11;
  localparam int S_DETB = 12;
  localparam int S_IND = 13;

  // register indices (byte address = index * 4)
  localparam logic [5:0] IDX_CMP = 6'h04;
  localparam logic [5:0] IDX_OV = 6'h0c;
  localparam logic [5:0] IDX_BP = 6'h0e;
  localparam logic [5:0] IDX_FLAG = 6'h1e;
  localparam logic [5:0] IDX_DETA = 6'h24;
  localparam logic [5:0] REG_IDX [NREG] = '{6'h00, 6'h02, IDX_CMP, 6'h06,
    6'h08, IDX_OV, IDX_BP, 6'h1a, IDX_FLAG, 6'h20, 6'h22, IDX_DETA,
    6'h26, 6'h2c};
  localparam logic [15:0] REG_RST [NREG] = '{16'h0001, 16'h00f2,
    16'h0004, 16'h0000, 16'h000f, 16'h0001, 16'h0001, 16'h0010,
    16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0044};
  localparam logic [15:0] REG_WMASK [NREG] = '{16'h0019, 16'h00f0,
    16'h000a, 16'h001f, 16'h000f, 16'h003f, 16'h0007, 16'h001f,
    16'h0001, 16'h0003, 16'h0037, 16'h000f, 16'h01ff, 16'h00ff};

  // field positions
  localparam int F_GLOBAL_EN = 4;
  localparam int F_HV_LSB = 4;
  localparam int F_CC_STAT = 7;
  localparam int F_CV_STAT = 6;
  localparam int F_CS_STAT = 5;
  localparam int F_CS_EN = 3;
  localparam int F_CV_EN = 1;
  localparam int F_OV_STAT = 6;
  localparam int F_OV_DEG = 5;
  localparam int F_OV_VTH_LSB = 1;
  localparam int F_OV_EN = 0;
  localparam int F_ABSENT_STAT = 12;
  localparam int F_TEMP_EN = 2;
  localparam int F_HOT_EN = 1;
  localparam int F_BP_EN = 0;
  localparam int F_WDT_KICK = 8;
  localparam int F_WDT_EN = 4;
  localparam int F_WDT_STAT = 2;
  localparam int F_WDT_FLAG_CLR = 1;
  localparam int F_WDT_IRQ_EN = 0;
  localparam int F_DL_SET = 3;
  localparam int F_DL_EXIT = 2;
  localparam int F_DET_CMP_STAT = 7;
  localparam int F_DET_RESET = 1;
  localparam int F_DET_OWNER = 0;
  localparam int F_DET_BIAS = 8;
  localparam int NROUTE = 4;
  localparam int ROUTE_SLOT [NROUTE] = '{S_DETA, S_DETB, S_DETB, S_DETB};
  localparam int ROUTE_LSB [NROUTE] = '{2, 6, 4, 2};
  localparam logic [1:0] ROUTE_FORBIDDEN = 2'h3;

  // synchronised inputs
  localparam int SY_CC = 0;
  localparam int SY_CV = 1;
  localparam int SY_CS = 2;
  localparam int SY_OV = 3;
  localparam int SY_ABSENT = 4;
  localparam int SY_DET = 5;
  localparam int SY_DL = 6;
  localparam int SY_UNDERVOLTAGE_LOCKOUT = 7;
  localparam int SY_DEEP_DISCHARGE_LOCKOUT = 8;
  localparam int SY_TEST = 9;
  localparam int SY_PLUG = 10;
  localparam int NSYNC = 11;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [11:0] wdt_limit_sec(input logic [3:0] code);
    case (code)
      4'h0: wdt_limit_sec = 12'h004;
      4'h1: wdt_limit_sec = 12'h008;
      4'h2: wdt_limit_sec = 12'h010;
      4'h3: wdt_limit_sec = 12'h020;
      4'h4: wdt_limit_sec = 12'h080;
      4'h5: wdt_limit_sec = 12'h100;
      4'h6: wdt_limit_sec = 12'h200;
      4'h7: wdt_limit_sec = 12'h400;
      default: wdt_limit_sec = WDT_LONG_SECONDS;
    endcase
  endfunction

  function automatic logic [15:0] wmerge(input logic [15:0] old,
    input logic [15:0] d, input logic [1:0] strb, input logic [15:0] mask);
    logic [15:0] m;
    m = mask & {{8{strb[1]}}, {8{strb[0]}}};
    wmerge = (old & ~m) | (d & m);
  endfunction

endpackage

// File: crw_regs.sv
// charger control/status register bank with watchdog, on AXI4-Lite
// assumes analogue comparator inputs are asynchronous to mclk
`timescale 1ns/1ps
module crw_regs
  import crw_pkg::*;
#(
  parameter int SEC_CYCLES_P = SEC_CYCLES,
  parameter int PLUGOUT_CYCLES_P = PLUGOUT_BASE_CYCLES
) (
  input logic mclk,
  input logic rst_b,
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic batt_cc_cmp,
  input logic batt_cv_cmp,
  input logic current_sense_cmp,
  input logic batt_ov_cmp,
  input logic batt_absent_cmp,
  input logic chg_detect_cmp,
  input logic dl_mode_hw_detect,
  input logic undervoltage_lockout,
  input logic deep_discharge_lockout,
  input logic charger_test_mode,
  input logic plugout_cmp,
  output logic charger_csdac_enable,
  output logic charger_auto_enable,
  output logic charger_hwcv_enable,
  output logic [3:0] input_hv_threshold_code,
  output logic [4:0] cv_threshold_code,
  output logic [3:0] current_sense_threshold_code,
  output logic current_sense_cmp_enable,
  output logic batt_cv_cmp_enable,
  output logic [2:0] batt_ov_threshold,
  output logic batt_ov_cmp_enable,
  output logic batt_ov_status,
  output logic batt_presence_cmp_enable,
  output logic batt_hot_detect_enable,
  output logic batt_temp_detect_enable,
  output logic [1:0] lockout_low_threshold,
  output logic dl_mode,
  output logic [3:0] wdt_timeout_code,
  output logic wdt_irq,
  output logic chg_detect_sw_owner,
  output logic chg_detect_hw_enable,
  output logic [1:0] chg_detect_vsrc_route,
  output logic [1:0] chg_detect_pullup_route,
  output logic [1:0] chg_detect_pulldown_route,
  output logic [1:0] chg_detect_cmp_route,
  output logic [1:0] chg_detect_ref_select,
  output logic chg_detect_bias_enable,
  output logic plugout_detect
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [NREG-1:0][15:0] regs;
    logic wdt_status;
    logic wdt_irq;
    logic wdt_kick;
    logic [3:0] wdt_code;
    logic dl_mode;
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [3:0] ov_cnt;
    logic ov_status;
    logic [17:0] po_presc;
    logic [5:0] po_cnt;
    logic po_det;
    logic [4:0] cv_applied;
    logic [2:0] ov_vth;
    logic [2*NROUTE-1:0] routes;
    logic det_hw_en;
    logic gate_en;
  } crw_st_t;

  function automatic logic [NREG-1:0][15:0] reg_reset();
    logic [NREG-1:0][15:0] v;
    for (int i = 0; i < NREG; i++) begin
      v[i] = REG_RST[i];
    end
    reg_reset = v;
  endfunction

  localparam crw_st_t ST_RESET = '{regs: reg_reset(), wdt_code: 4'h0,
    default: '0};

  crw_st_t st_reg;
  crw_st_t st_next;
  logic wdt_expire;
  logic wdt_run;
  logic [3:0] wdt_code_eff;

  assign wdt_run = st_reg.s2[SY_UNDERVOLTAGE_LOCKOUT] |
    (st_reg.regs[S_WDT][F_WDT_EN] &
     (st_reg.s2[SY_TEST] | st_reg.regs[S_MAIN][F_GLOBAL_EN]));
  assign wdt_code_eff = st_reg.s2[SY_UNDERVOLTAGE_LOCKOUT] ? WDT_LOCKOUT_CODE :
    st_reg.wdt_code;

  crw_wdt #(
    .SEC_CYCLES_P(SEC_CYCLES_P)
  ) u_wdt (
    .mclk(mclk),
    .rst_b(rst_b),
    .run(wdt_run),
    .restart(st_reg.wdt_kick),
    .code(wdt_code_eff),
    .expire(wdt_expire)
  );

  always_comb begin
    logic wr_fire;
    logic whit;
    logic rhit;
    logic [5:0] widx;
    logic [5:0] ridx;
    logic [15:0] rword;
    logic [1:0] strb;
    logic kick;
    logic dl_set;
    logic dl_exit;
    logic flag_clr;
    logic absent;
    logic [1:0] fld;
    logic [5:0] po_code;
    wr_fire = st_reg.awready;
    whit = 1'b0;
    rhit = 1'b0;
    widx = s_axi_awaddr[7:2];
    ridx = s_axi_araddr[7:2];
    rword = 16'h0000;
    strb = s_axi_wstrb[1:0];
    fld = 2'h0;
    kick = 1'b0;
    dl_set = 1'b0;
    dl_exit = 1'b0;
    flag_clr = 1'b0;
    absent = 1'b0;
    po_code = 6'h00;
    st_next = st_reg;
    st_next.awready = 1'b0;
    st_next.wready = 1'b0;
    st_next.arready = 1'b0;

    // input synchronisers
    st_next.s1 = {plugout_cmp, charger_test_mode, deep_discharge_lockout,
      undervoltage_lockout, dl_mode_hw_detect, chg_detect_cmp,
      batt_absent_cmp, batt_ov_cmp, current_sense_cmp, batt_cv_cmp,
      batt_cc_cmp};
    st_next.s2 = st_reg.s1;

    // register writes and reads
    for (int i = 0; i < NREG; i++) begin
      if (wr_fire && widx == REG_IDX[i]) begin
        whit = 1'b1;
        st_next.regs[i] = wmerge(st_reg.regs[i], s_axi_wdata[15:0], strb,
          REG_WMASK[i]);
      end
      if (ridx == REG_IDX[i]) begin
        rhit = 1'b1;
        rword = st_reg.regs[i];
      end
    end

    // write-one pulses
    kick = wr_fire && widx == REG_IDX[S_WDT] && strb[1] &&
      s_axi_wdata[F_WDT_KICK];
    dl_set = wr_fire && widx == REG_IDX[S_DL] && strb[0] &&
      s_axi_wdata[F_DL_SET];
    dl_exit = wr_fire && widx == REG_IDX[S_DL] && strb[0] &&
      s_axi_wdata[F_DL_EXIT];
    flag_clr = wr_fire && widx == IDX_FLAG && strb[0] &&
      s_axi_wdata[F_WDT_FLAG_CLR] && st_reg.wdt_status;

    st_next.wdt_kick = kick;
    if (kick) begin
      st_next.wdt_code = st_next.regs[S_WDT][3:0];
    end

    // expiry wins over a clear in the same cycle
    st_next.wdt_status = wdt_expire | (st_reg.wdt_status & ~flag_clr);
    st_next.wdt_irq = st_reg.wdt_status &
      st_reg.regs[S_FLAG][F_WDT_IRQ_EN];

    st_next.dl_mode = st_reg.s2[SY_DL] | dl_set |
      (st_reg.dl_mode & ~dl_exit);

    // over-voltage report with optional deglitch
    if (!st_reg.regs[S_OV][F_OV_EN] || !st_reg.s2[SY_OV]) begin
      st_next.ov_cnt = 4'h0;
      st_next.ov_status = 1'b0;
    end else if (!st_reg.regs[S_OV][F_OV_DEG]) begin
      st_next.ov_status = 1'b1;
    end else if (st_reg.ov_cnt == 4'(OV_DEG_CYCLES - 1)) begin
      st_next.ov_status = 1'b1;
    end else begin
      st_next.ov_cnt = st_reg.ov_cnt + 4'h1;
    end

    // plug-out debounce in 16 ms steps
    po_code = st_reg.regs[S_IND][5:0];
    if (!st_reg.s2[SY_PLUG]) begin
      st_next.po_presc = 18'h0_0000;
      st_next.po_cnt = 6'h00;
      st_next.po_det = 1'b0;
    end else if (st_reg.po_cnt >= po_code) begin
      st_next.po_det = 1'b1;
    end else if (st_reg.po_presc == 18'(PLUGOUT_CYCLES_P - 1)) begin
      st_next.po_presc = 18'h0_0000;
      st_next.po_cnt = st_reg.po_cnt + 6'h01;
    end else begin
      st_next.po_presc = st_reg.po_presc + 18'h0_0001;
    end

    // applied analogue codes
    st_next.cv_applied = {~st_reg.regs[S_CV][4],
      st_reg.regs[S_CV][3:0]};
    st_next.ov_vth = st_reg.regs[S_OV][F_OV_VTH_LSB + 2] ? 3'h4 :
      st_reg.regs[S_OV][F_OV_VTH_LSB +: 3];
    for (int i = 0; i < NROUTE; i++) begin
      fld = st_reg.regs[ROUTE_SLOT[i]][ROUTE_LSB[i] +: 2];
      st_next.routes[2*i +: 2] = (fld == ROUTE_FORBIDDEN) ? 2'h0 : fld;
    end
    st_next.det_hw_en = ~st_reg.regs[S_DETA][F_DET_OWNER] &
      ~st_reg.regs[S_DETA][F_DET_RESET];
    st_next.gate_en = st_reg.regs[S_MAIN][F_GLOBAL_EN];

    // status bits merged on read
    absent = st_reg.regs[S_BP][F_BP_EN] & ~st_reg.s2[SY_UNDERVOLTAGE_LOCKOUT] &
      ~st_reg.s2[SY_DEEP_DISCHARGE_LOCKOUT] & st_reg.s2[SY_ABSENT];
    if (ridx == IDX_CMP) begin
      rword[F_CC_STAT] = st_reg.s2[SY_CC];
      rword[F_CV_STAT] = st_reg.s2[SY_CV];
      rword[F_CS_STAT] = st_reg.s2[SY_CS];
    end
    if (ridx == IDX_OV) begin
      rword[F_OV_STAT] = st_reg.ov_status;
    end
    if (ridx == IDX_BP) begin
      rword[F_ABSENT_STAT] = absent;
    end
    if (ridx == IDX_FLAG) begin
      rword[F_WDT_STAT] = st_reg.wdt_status;
    end
    if (ridx == IDX_DETA) begin
      rword[F_DET_CMP_STAT] = st_reg.s2[SY_DET];
    end

    // write channel
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (wr_fire) begin
      st_next.bvalid = 1'b1;
      st_next.bresp = whit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_awvalid && s_axi_wvalid && !st_reg.bvalid) begin
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end

    // read channel
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = {16'h0000, rword};
      st_next.rresp = rhit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_arvalid && !st_reg.rvalid) begin
      st_next.arready = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign charger_csdac_enable = st_reg.gate_en;
  assign charger_auto_enable = st_reg.gate_en;
  assign charger_hwcv_enable = st_reg.gate_en;
  assign input_hv_threshold_code =
    st_reg.regs[S_HV][F_HV_LSB +: 4];
  assign cv_threshold_code = st_reg.cv_applied;
  assign current_sense_threshold_code = st_reg.regs[S_CS][3:0];
  assign current_sense_cmp_enable = st_reg.regs[S_CMP][F_CS_EN];
  assign batt_cv_cmp_enable = st_reg.regs[S_CMP][F_CV_EN];
  assign batt_ov_threshold = st_reg.ov_vth;
  assign batt_ov_cmp_enable = st_reg.regs[S_OV][F_OV_EN];
  assign batt_ov_status = st_reg.ov_status;
  assign batt_presence_cmp_enable = st_reg.regs[S_BP][F_BP_EN];
  assign batt_hot_detect_enable = st_reg.regs[S_BP][F_HOT_EN];
  assign batt_temp_detect_enable = st_reg.regs[S_BP][F_TEMP_EN];
  assign lockout_low_threshold = st_reg.regs[S_DL][1:0];
  assign dl_mode = st_reg.dl_mode;
  assign wdt_timeout_code = st_reg.wdt_code;
  assign wdt_irq = st_reg.wdt_irq;
  assign chg_detect_sw_owner = st_reg.regs[S_DETA][F_DET_OWNER];
  assign chg_detect_hw_enable = st_reg.det_hw_en;
  assign chg_detect_vsrc_route = st_reg.routes[1:0];
  assign chg_detect_pullup_route = st_reg.routes[3:2];
  assign chg_detect_pulldown_route = st_reg.routes[5:4];
  assign chg_detect_cmp_route = st_reg.routes[7:6];
  assign chg_detect_ref_select = st_reg.regs[S_DETB][1:0];
  assign chg_detect_bias_enable = st_reg.regs[S_DETB][F_DET_BIAS];
  assign plugout_detect = st_reg.po_det;

endmodule

// File: crw_regs_props.sv
// port-level assertions for the charger control register bank
// assumes a bind from the bench top onto crw_regs
`timescale 1ns/1ps
module crw_regs_props
  import crw_pkg::*;
(
  input logic mclk,
  input logic rst_b,
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic dl_mode_hw_detect,
  input logic dl_mode,
  input logic wdt_irq,
  input logic charger_csdac_enable,
  input logic charger_auto_enable,
  input logic charger_hwcv_enable,
  input logic [1:0] chg_detect_vsrc_route,
  input logic [1:0] chg_detect_pullup_route,
  input logic [2:0] batt_ov_threshold
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic wr;
  assign wr = s_axi_awvalid && s_axi_awready;
  a_gate_agree: assert property (
    charger_csdac_enable == charger_auto_enable &&
    charger_auto_enable == charger_hwcv_enable) else $error("gates differ");
  a_route_legal: assert property (
    chg_detect_vsrc_route != 2'h3 && chg_detect_pullup_route != 2'h3)
    else $error("route code 3 driven");
  a_ov_thr_norm: assert property (
    batt_ov_threshold[2] |-> batt_ov_threshold[1:0] == 2'h0)
    else $error("ov code not normalised");
  a_dl_set: assert property (
    wr && s_axi_awaddr[7:2] == 6'h20 && s_axi_wdata[3] |-> ##[1:3] dl_mode)
    else $error("dl set ignored");
  a_dl_hw_wins: assert property (
    dl_mode_hw_detect [*4] |=> dl_mode) else $error("hw detect lost");
  a_irq_clear: assert property (
    wr && s_axi_awaddr[7:2] == IDX_FLAG && s_axi_wdata[1] |-> ##[1:3] !wdt_irq)
    else $error("irq not cleared");
  a_write_answer: assert property (wr |=> s_axi_bvalid)
    else $error("no write response");
  a_bad_addr: assert property (wr && s_axi_awaddr[7:2] > 6'h2c |=>
    s_axi_bresp == RESP_SLVERR) else $error("unmapped write accepted");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("response dropped");
  c_dl: cover property ($rose(dl_mode));
  c_irq: cover property ($rose(wdt_irq));
  c_bad: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

// File: crw_regs_tb.sv
// self-checking bench for the charger control register bank
// assumes shortened second (10 cycles) and plug-out base counts
`timescale 1ns/1ps
module crw_regs_tb
  import crw_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic batt_cc_cmp = 1'b0, batt_cv_cmp = 1'b0, current_sense_cmp = 1'b0;
  logic batt_ov_cmp = 1'b0, batt_absent_cmp = 1'b0, dl_mode_hw_detect = 1'b0;
  logic undervoltage_lockout = 1'b0, deep_discharge_lockout = 1'b0;
  logic charger_test_mode = 1'b0, plugout_cmp = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, lockout_low_threshold;
  logic [31:0] s_axi_rdata, rd;
  logic [1:0] rsp;
  logic charger_csdac_enable, charger_auto_enable, charger_hwcv_enable;
  logic [3:0] input_hv_threshold_code, current_sense_threshold_code;
  logic [3:0] wdt_timeout_code;
  logic [4:0] cv_threshold_code;
  logic [2:0] batt_ov_threshold;
  logic batt_ov_status, dl_mode, wdt_irq, plugout_detect;
  logic chg_detect_sw_owner, chg_detect_hw_enable;
  logic [1:0] chg_detect_vsrc_route, chg_detect_pullup_route;
  logic [1:0] chg_detect_pulldown_route, chg_detect_cmp_route;
  int failures = 0;
  int check_count = 0;

  crw_regs #(.SEC_CYCLES_P(10), .PLUGOUT_CYCLES_P(4)) DUT (
    .mclk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .batt_cc_cmp, .batt_cv_cmp, .current_sense_cmp, .batt_ov_cmp,
    .batt_absent_cmp, .chg_detect_cmp(1'b0), .dl_mode_hw_detect,
    .undervoltage_lockout, .deep_discharge_lockout, .charger_test_mode,
    .plugout_cmp, .charger_csdac_enable, .charger_auto_enable,
    .charger_hwcv_enable, .input_hv_threshold_code, .cv_threshold_code,
    .current_sense_threshold_code, .current_sense_cmp_enable(),
    .batt_cv_cmp_enable(), .batt_ov_threshold, .batt_ov_cmp_enable(),
    .batt_ov_status, .batt_presence_cmp_enable(), .batt_hot_detect_enable(),
    .batt_temp_detect_enable(), .lockout_low_threshold, .dl_mode,
    .wdt_timeout_code, .wdt_irq, .chg_detect_sw_owner, .chg_detect_hw_enable,
    .chg_detect_vsrc_route, .chg_detect_pullup_route,
    .chg_detect_pulldown_route, .chg_detect_cmp_route,
    .chg_detect_ref_select(), .chg_detect_bias_enable(), .plugout_detect
  );

  always #50 mclk = ~mclk;

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [5:0] i, input logic [15:0] d);
    @(posedge mclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    repeat (20) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk("bvalid", 1, s_axi_bvalid);
  endtask

  task automatic rchk(input string what, input logic [5:0] i,
    input logic [15:0] e);
    @(posedge mclk);
    s_axi_araddr <= {i, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    repeat (20) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(what, {16'h0000, e}, rd);
  endtask

  task automatic irq_win(input int lo, input int span);
    tick(lo);
    chk("irq early", 0, wdt_irq);
    repeat (span) if (wdt_irq !== 1'b1) tick(1);
    chk("irq late", 1, wdt_irq);
  endtask

  task automatic t_reset();
    logic [15:0] ex [NREG] = '{16'h0001, 16'h00f2, 16'h0004, 16'h0000,
      16'h000f, 16'h0001, 16'h0001, 16'h0010, 16'h0000, 16'h0001, 16'h0000,
      16'h0000, 16'h0000, 16'h0044};
    for (int i = 0; i < NREG; i++) rchk("reset", REG_IDX[i], ex[i]);
    chk("cs code", 4'hf, current_sense_threshold_code);
    chk("hv code", 4'hf, input_hv_threshold_code);
    chk("cv code", 5'h10, cv_threshold_code);
    rchk("bad read", 6'h3f, 16'h0000);
    chk("bad read resp", RESP_SLVERR, rsp);
    wr(6'h3f, 16'hffff);
    chk("bad write resp", RESP_SLVERR, rsp);
  endtask

  task automatic t_fields();
    logic [1:0] e;
    wr(6'h06, 16'h000f);
    tick(3);
    chk("cv code", 5'h1f, cv_threshold_code);
    for (int c = 0; c < 8; c++) begin
      wr(IDX_OV, 16'(c << 1) | 16'h0001);
      tick(3);
      chk("ov thr", c[2] ? 3'h4 : c[2:0], batt_ov_threshold);
    end
    for (int c = 0; c < 4; c++) begin
      wr(IDX_DETA, 16'(c << 2));
      wr(6'h26, 16'(c * 16'h0054));
      tick(3);
      e = (c == 3) ? 2'h0 : c[1:0];
      chk("routes", {4{e}}, {chg_detect_vsrc_route, chg_detect_pullup_route,
        chg_detect_pulldown_route, chg_detect_cmp_route});
    end
    wr(IDX_DETA, 16'h0001);
    tick(3);
    chk("sw owner", 2'h2, {chg_detect_sw_owner, chg_detect_hw_enable});
    wr(IDX_DETA, 16'h0002);
    tick(3);
    chk("det reset", 2'h0, {chg_detect_sw_owner, chg_detect_hw_enable});
    wr(IDX_DETA, 16'h0000);
    tick(3);
    chk("hw owner", 2'h1, {chg_detect_sw_owner, chg_detect_hw_enable});
    wr(6'h00, 16'h0010);
    tick(3);
    chk("gates", 3'h7, {charger_csdac_enable, charger_auto_enable,
      charger_hwcv_enable});
    @(posedge mclk) {batt_cc_cmp, batt_cv_cmp, current_sense_cmp} <= 3'h7;
    tick(4);
    rchk("cmp status", IDX_CMP, 16'h00e4);
  endtask

  task automatic t_dl();
    for (int c = 0; c < 4; c++) begin
      wr(6'h20, 16'(c));
      tick(3);
      chk("lockout thr", c[1:0], lockout_low_threshold);
    end
    wr(6'h20, 16'h0009);
    tick(3);
    chk("dl set", 1, dl_mode);
    wr(6'h20, 16'h0001);
    tick(3);
    chk("dl zero", 1, dl_mode);
    @(posedge mclk) dl_mode_hw_detect <= 1'b1;
    tick(5);
    wr(6'h20, 16'h0005);
    tick(3);
    chk("dl hw wins", 1, dl_mode);
    dl_mode_hw_detect <= 1'b0;
    tick(5);
    wr(6'h20, 16'h0005);
    tick(3);
    chk("dl exit", 0, dl_mode);
  endtask

  task automatic ovp(input int n, input logic e);
    logic seen;
    seen = 1'b0;
    @(posedge mclk) batt_ov_cmp <= 1'b1;
    repeat (n + 14) begin
      @(posedge mclk);
      if (--n == 0) batt_ov_cmp <= 1'b0;
      seen |= batt_ov_status;
    end
    chk("ov seen", e, seen);
  endtask

  task automatic t_ov();
    wr(IDX_OV, 16'h0001);
    ovp(2, 1'b1);
    wr(IDX_OV, 16'h0021);
    ovp(8, 1'b0);
    ovp(12, 1'b1);
  endtask

  task automatic t_plug();
    plugout_cmp <= 1'b1;
    tick(15);
    chk("plugout early", 0, plugout_detect);
    tick(8);
    chk("plugout", 1, plugout_detect);
    @(posedge mclk) plugout_cmp <= 1'b0;
    tick(4);
    chk("plugout drop", 0, plugout_detect);
  endtask

  task automatic t_wdt();
    // flag left set by the run since global enable came on
    wr(IDX_FLAG, 16'h0003);
    for (int c = 0; c < 8; c++) begin
      wr(6'h1a, 16'h0110 | 16'(c));
      tick(3);
      chk("wdt code", c[3:0], wdt_timeout_code);
      irq_win((c < 4 ? 4 << c : 8 << c) * 10 - 12, 24);
      rchk("flags set", IDX_FLAG, 16'h0005);
      wr(IDX_FLAG, 16'h0003);
      tick(2);
      rchk("flags clear", IDX_FLAG, 16'h0001);
    end
    wr(6'h00, 16'h0000);
    wr(6'h1a, 16'h0110);
    tick(100);
    chk("wdt gated", 0, wdt_irq);
    @(posedge mclk) charger_test_mode <= 1'b1;
    irq_win(28, 30);
    wr(IDX_FLAG, 16'h0002);
    charger_test_mode <= 1'b0;
    {undervoltage_lockout, batt_absent_cmp} <= 2'h3;
    tick(4);
    rchk("absent undervoltage_lockout", IDX_BP, 16'h0001);
    wr(6'h1a, 16'h010c);
    tick(29985);
    rchk("no lockout expiry", IDX_FLAG, 16'h0000);
    tick(30);
    rchk("lockout expiry", IDX_FLAG, 16'h0004);
    chk("irq masked", 0, wdt_irq);
    {undervoltage_lockout, deep_discharge_lockout} <= 2'h1;
    tick(4);
    rchk("absent deep_discharge_lockout", IDX_BP, 16'h0001);
    deep_discharge_lockout <= 1'b0;
    tick(4);
    rchk("absent", IDX_BP, 16'h1001);
    wr(IDX_BP, 16'h0000);
    tick(4);
    rchk("absent off", IDX_BP, 16'h0000);
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    $display("reset test done, failures %0d", failures);
    t_fields();
    $display("field test done, failures %0d", failures);
    t_dl();
    $display("download test done, failures %0d", failures);
    t_ov();
    $display("over-voltage test done, failures %0d", failures);
    t_plug();
    $display("plug-out test done, failures %0d", failures);
    t_wdt();
    $display("watchdog test done, failures %0d", failures);
    final_report();
  end

  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    final_report();
  end
endmodule

bind crw_regs crw_regs_props u_props (.mclk, .rst_b, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .dl_mode_hw_detect, .dl_mode, .wdt_irq,
  .charger_csdac_enable, .charger_auto_enable, .charger_hwcv_enable,
  .chg_detect_vsrc_route, .chg_detect_pullup_route, .batt_ov_threshold);

// File: crw_wdt.sv
// charger watchdog: one-second prescaler and seconds counter
// assumes restart and run come from logic on mclk
`timescale 1ns/1ps
module crw_wdt
  import crw_pkg::*;
#(
  parameter int SEC_CYCLES_P = SEC_CYCLES
) (
  input logic mclk,
  input logic rst_b,
  input logic run,
  input logic restart,
  input logic [3:0] code,
  output logic expire
);

  typedef struct packed {
    logic [23:0] presc;
    logic [11:0] secs;
    logic done;
    logic expire;
  } crw_wdt_st_t;

  crw_wdt_st_t st_reg;
  crw_wdt_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.expire = 1'b0;
    if (restart) begin
      st_next.presc = '0;
      st_next.secs = '0;
      st_next.done = 1'b0;
    end else if (run && !st_reg.done) begin
      if (st_reg.presc == 24'(SEC_CYCLES_P - 1)) begin
        st_next.presc = '0;
        if (st_reg.secs + 12'h001 >= wdt_limit_sec(code)) begin
          st_next.done = 1'b1;
          st_next.expire = 1'b1;
        end else begin
          st_next.secs = st_reg.secs + 12'h001;
        end
      end else begin
        st_next.presc = st_reg.presc + 24'h00_0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign expire = st_reg.expire;

endmodule
